// ### tile_cfg_pkg.sv
// Purpose : shared constants for the tile configuration register bank
// Assumes : register numbers are word indices on the configuration port
// Notes   : all field positions and reset values live here
package tile_cfg_pkg;

   // ---------------------------------------------------------------
   // register numbers
   // ---------------------------------------------------------------
   localparam logic [7:0] NUM_CAPABILITY   = 8'h02;
   localparam logic [7:0] NUM_DBG_PERM     = 8'h04;
   localparam logic [7:0] NUM_DEBUG_INTERRUPT_REQUEST      = 8'h05;
   localparam logic [7:0] NUM_CLK_DIV      = 8'h06;
   localparam logic [7:0] NUM_SECURITY     = 8'h07;
   localparam logic [7:0] NUM_SCRATCH_BASE = 8'h20;
   localparam logic [7:0] NUM_SCRATCH_LAST = 8'h27;
   localparam logic [7:0] NUM_CORE0_PC     = 8'h40;

   // ---------------------------------------------------------------
   // access sources
   // ---------------------------------------------------------------
   localparam logic [1:0] SRC_LOCAL   = 2'h0;
   localparam logic [1:0] SRC_SWITCH  = 2'h1;
   localparam logic [1:0] SRC_SCRATCH = 2'h2;
   localparam logic [1:0] SRC_JTAG    = 2'h3;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int CAP_CLKBLK_LSB   = 8;
   localparam int CAP_TIMER_LSB    = 0;
   localparam int PERM_ALL_BIT     = 31;
   localparam int PERM_SWITCH_BIT  = 0;
   localparam int DINT_REQ_BIT     = 0;
   localparam int DINT_IN_DBG_BIT  = 1;
   localparam int DIV_DISABLE_BIT  = 31;
   localparam int DIV_WIDTH        = 16;
   localparam int SEC_WLOCK_BIT    = 31;
   localparam int SEC_GDBG_BIT     = 14;
   localparam int SEC_OTP_ALL_BIT  = 12;
   localparam int SEC_SECT_MSB     = 11;
   localparam int SEC_SECT_LSB     = 8;
   localparam int SEC_OTP_RED_BIT  = 7;
   localparam int SEC_BOOT_OTP_BIT = 5;
   localparam int SEC_JTAG_PLL_BIT = 4;
   localparam int SEC_JTAG_TAP_BIT = 0;
   localparam int SCRATCH_WORDS    = 8;

   // ---------------------------------------------------------------
   // reset values and masks
   // ---------------------------------------------------------------
   localparam logic [31:0] WORD_ZERO   = 32'h0000_0000;
   localparam logic [31:0] SEC_MASK    = 32'h8000_5FB1;
   localparam logic [15:0] DIV_RESET   = 16'h0000;
   localparam logic [7:0]  COUNT_RESET = 8'h00;

endpackage

// ### tile_clock_divider.sv
// Purpose : turns the pll clock into a tile clock enable by division
// Assumes : mclk stands for the pll clock
// Notes   : divide values 0 and 1 both give an undivided clock
`timescale 1ns/1ps
module tile_clock_divider
   import tile_cfg_pkg::*;
(
   input  wire logic                 mclk,
   input  wire logic                 rst_b,
   input  wire logic [DIV_WIDTH-1:0] divide_value,
   input  wire logic                 divider_enable,
   input  wire logic                 gate_off,
   output logic                      tile_tick
);

   logic [DIV_WIDTH-1:0] count_reg;

   // held value is ignored unless the tile control enable is set
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         count_reg <= DIV_RESET;
         tile_tick <= 1'b0;
      end else if (gate_off) begin
         count_reg <= DIV_RESET;
         tile_tick <= 1'b0;
      end else if (!divider_enable || divide_value <= DIV_WIDTH'(1)) begin
         count_reg <= DIV_RESET;
         tile_tick <= 1'b1;
      end else if (count_reg >= divide_value - DIV_WIDTH'(1)) begin
         count_reg <= DIV_RESET;
         tile_tick <= 1'b1;
      end else begin
         count_reg <= count_reg + DIV_WIDTH'(1);
         tile_tick <= 1'b0;
      end
   end

endmodule

// ### debug_scratch_store.sv
// Purpose : eight scratch words shared by the config port and the core
// Assumes : one write per port per cycle
// Notes   : the config port wins when both write the same word
`timescale 1ns/1ps
module debug_scratch_store
   import tile_cfg_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst_b,
   input  wire logic        cfg_we,
   input  wire logic [2:0]  cfg_idx,
   input  wire logic [31:0] cfg_wdata,
   output logic      [31:0] cfg_word,
   input  wire logic        core_req,
   input  wire logic        core_we,
   input  wire logic [2:0]  core_idx,
   input  wire logic [31:0] core_wdata,
   output logic      [31:0] core_rdata,
   output logic             core_ack
);

   logic [31:0] mem [SCRATCH_WORDS];

   genvar gi;
   generate
      for (gi = 0; gi < SCRATCH_WORDS; gi++) begin : g_word
         always_ff @(posedge mclk or negedge rst_b) begin
            if (!rst_b) begin
               mem[gi] <= WORD_ZERO;
            end else if (cfg_we && cfg_idx == 3'(gi)) begin
               mem[gi] <= cfg_wdata;
            end else if (core_req && core_we && core_idx == 3'(gi)) begin
               mem[gi] <= core_wdata;
            end
         end
      end
   endgenerate

   assign cfg_word = mem[cfg_idx];

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         core_rdata <= WORD_ZERO;
         core_ack   <= 1'b0;
      end else begin
         core_ack   <= core_req;
         core_rdata <= core_req ? mem[core_idx] : WORD_ZERO;
      end
   end

endmodule

// ### tile_config_debug_regs.sv
// Purpose : tile configuration and debug register bank
// Assumes : cfg_req is a one-cycle strobe, answered one cycle later
// Notes   : refused writes answer with cfg_err; ignored writes do not
// Function
// R1: capability bits 15:8 give clock block count
// R2: capability bits 7:0 give timers, rest zero
// R3: permission bit 31 blocks switch, scratch, jtag
// R4: permission bit 0 blocks switch writes only
// R5: restricted sources get their writes rejected
// R6: writing one to bit 0 requests debug interrupt
// R7: bit 1 shows processor debug mode
// R8: tile clock is pll divided by value
// R9: divider applies only when control enable set
// R10: bit 31 of divider gates tile clock
// R11: security register copies otp security word
// R12: security bit 31 refuses writes to it
// R13: security bit 14 blocks global debug
// R14: bit 12 locks all otp, 11:8 per sector
// R15: security bit 5 forces boot from otp
// R16: security bit 4 blocks jtag pll access
// R17: security bit 0 blocks jtag debug tap
// R18: eight scratch words shared with status space
// R19: scratch words are debugger mailbox over switch
// R20: register 0x40 returns core 0 pc
// R21: agent uses config reads and writes only
// R22: reserved bits read zero, ro writes ignored
`timescale 1ns/1ps
module tile_config_debug_regs
   import tile_cfg_pkg::*;
#(
   parameter logic [7:0] TIMER_COUNT  = 8'h0A,
   parameter logic [7:0] CLKBLK_COUNT = 8'h06
)
(
   input  wire logic        mclk,
   input  wire logic        rst_b,
   // configuration access port
   input  wire logic        cfg_req,
   input  wire logic        cfg_write,
   input  wire logic [1:0]  cfg_src,
   input  wire logic [7:0]  cfg_num,
   input  wire logic [31:0] cfg_wdata,
   output logic      [31:0] cfg_rdata,
   output logic             cfg_ack,
   output logic             cfg_err,
   // processor status space scratch port
   input  wire logic        core_scr_req,
   input  wire logic        core_scr_write,
   input  wire logic [2:0]  core_scr_idx,
   input  wire logic [31:0] core_scr_wdata,
   output logic      [31:0] core_scr_rdata,
   output logic             core_scr_ack,
   // processor state
   input  wire logic        in_debug_mode,
   input  wire logic [31:0] core0_pc,
   input  wire logic        divider_enable,
   input  wire logic        otp_load,
   input  wire logic [31:0] otp_security_word,
   // controls to the tile
   output logic             debug_irq_req,
   output logic             tile_clk_tick,
   output logic             tile_clk_gated,
   output logic             global_debug_block,
   output logic             jtag_debug_port_block,
   output logic             jtag_pll_block,
   output logic             boot_from_otp_override,
   output logic             otp_all_sector_lock,
   output logic [3:0]       otp_per_sector_lock,
   output logic             otp_redundancy_enable
);

   // ---------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------
   logic                 switch_only_read_restrict;
   logic                 all_source_restrict;
   logic                 debug_interrupt_trigger;
   logic                 in_debug_mode_flag;
   logic                 in_debug_prev;
   logic                 clock_disable;
   logic [DIV_WIDTH-1:0] clock_divide;
   logic [31:0]          security_configuration;
   logic [31:0]          scratch_word;

   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   logic hit_cap;
   logic hit_perm;
   logic hit_dint;
   logic hit_div;
   logic hit_sec;
   logic hit_scr;
   logic hit_pc;
   logic mapped;
   logic wr_req;
   logic restricted;
   logic jtag_pll_refused;
   logic sec_refused;
   logic write_ok;
   logic core_scr_blocked;

   assign hit_cap  = (cfg_num == NUM_CAPABILITY);
   assign hit_perm = (cfg_num == NUM_DBG_PERM);
   assign hit_dint = (cfg_num == NUM_DEBUG_INTERRUPT_REQUEST);
   assign hit_div  = (cfg_num == NUM_CLK_DIV);
   assign hit_sec  = (cfg_num == NUM_SECURITY);
   assign hit_scr  = (cfg_num >= NUM_SCRATCH_BASE) && (cfg_num <= NUM_SCRATCH_LAST);
   assign hit_pc   = (cfg_num == NUM_CORE0_PC);
   assign mapped   = hit_cap | hit_perm | hit_dint | hit_div | hit_sec | hit_scr | hit_pc;
   assign wr_req   = cfg_req && cfg_write;

   // the restriction covers its own register, so the sources it blocks cannot undo it
   assign restricted =
      (all_source_restrict && (cfg_src == SRC_SWITCH || cfg_src == SRC_SCRATCH
                               || cfg_src == SRC_JTAG)) ||  // R3 R5
      (switch_only_read_restrict && cfg_src == SRC_SWITCH);  // R4 R5

   assign jtag_pll_refused = security_configuration[SEC_JTAG_PLL_BIT]
                             && cfg_src == SRC_JTAG && hit_div;  // R16
   assign sec_refused      = security_configuration[SEC_WLOCK_BIT] && hit_sec;  // R12

   assign write_ok = wr_req && !restricted && !jtag_pll_refused;

   // core scratch writes come in through the scratch path
   assign core_scr_blocked = all_source_restrict;  // R3

   // ---------------------------------------------------------------
   // permission register
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         all_source_restrict       <= 1'b0;
         switch_only_read_restrict <= 1'b0;
      end else if (write_ok && hit_perm) begin
         all_source_restrict       <= cfg_wdata[PERM_ALL_BIT];  // R3
         switch_only_read_restrict <= cfg_wdata[PERM_SWITCH_BIT];  // R4
      end
   end

   // ---------------------------------------------------------------
   // debug interrupt
   // ---------------------------------------------------------------
   // the request stays up until the core is seen entering debug mode;
   // a new request in that same cycle wins over the clear
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         debug_interrupt_trigger <= 1'b0;
      end else if (write_ok && hit_dint && cfg_wdata[DINT_REQ_BIT]) begin
         debug_interrupt_trigger <= 1'b1;  // R6
      end else if (in_debug_mode && !in_debug_prev) begin
         debug_interrupt_trigger <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         in_debug_mode_flag <= 1'b0;
         in_debug_prev      <= 1'b0;
      end else begin
         in_debug_mode_flag <= in_debug_mode;  // R7
         in_debug_prev      <= in_debug_mode;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         debug_irq_req <= 1'b0;
      end else begin
         debug_irq_req <= debug_interrupt_trigger
                          && !security_configuration[SEC_GDBG_BIT];  // R13
      end
   end

   // ---------------------------------------------------------------
   // clock divider
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         clock_divide  <= DIV_RESET;
         clock_disable <= 1'b0;
      end else if (write_ok && hit_div) begin
         clock_divide  <= cfg_wdata[DIV_WIDTH-1:0];  // R8
         clock_disable <= cfg_wdata[DIV_DISABLE_BIT];  // R10
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         tile_clk_gated <= 1'b0;
      end else begin
         tile_clk_gated <= clock_disable;  // R10
      end
   end

   tile_clock_divider u_div (
      .mclk           (mclk),
      .rst_b          (rst_b),
      .divide_value   (clock_divide),
      .divider_enable (divider_enable),  // R9
      .gate_off       (clock_disable),
      .tile_tick      (tile_clk_tick)
   );

   // ---------------------------------------------------------------
   // security copy
   // ---------------------------------------------------------------
   // captured by a clocked load after reset, never by the reset itself
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         security_configuration <= WORD_ZERO;
      end else if (otp_load) begin
         security_configuration <= otp_security_word & SEC_MASK;  // R11 R22
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         global_debug_block     <= 1'b0;
         jtag_debug_port_block  <= 1'b0;
         jtag_pll_block         <= 1'b0;
         boot_from_otp_override <= 1'b0;
         otp_all_sector_lock    <= 1'b0;
         otp_per_sector_lock    <= 4'h0;
         otp_redundancy_enable  <= 1'b0;
      end else begin
         global_debug_block     <= security_configuration[SEC_GDBG_BIT];  // R13
         jtag_debug_port_block  <= security_configuration[SEC_JTAG_TAP_BIT];  // R17
         jtag_pll_block         <= security_configuration[SEC_JTAG_PLL_BIT];  // R16
         boot_from_otp_override <= security_configuration[SEC_BOOT_OTP_BIT];  // R15
         otp_all_sector_lock    <= security_configuration[SEC_OTP_ALL_BIT];  // R14
         otp_per_sector_lock    <= security_configuration[SEC_SECT_MSB:SEC_SECT_LSB];  // R14
         otp_redundancy_enable  <= security_configuration[SEC_OTP_RED_BIT];
      end
   end

   // ---------------------------------------------------------------
   // scratch words
   // ---------------------------------------------------------------
   debug_scratch_store u_scr (
      .mclk       (mclk),
      .rst_b      (rst_b),
      .cfg_we     (write_ok && hit_scr),  // R18 R19
      .cfg_idx    (cfg_num[2:0]),
      .cfg_wdata  (cfg_wdata),
      .cfg_word   (scratch_word),
      .core_req   (core_scr_req),
      .core_we    (core_scr_write && !core_scr_blocked),  // R18
      .core_idx   (core_scr_idx),
      .core_wdata (core_scr_wdata),
      .core_rdata (core_scr_rdata),
      .core_ack   (core_scr_ack)
   );

   // ---------------------------------------------------------------
   // read mux and answer
   // ---------------------------------------------------------------
   logic [31:0] read_word;

   always_comb begin
      read_word = WORD_ZERO;
      if (hit_cap) begin
         read_word = {16'h0000, CLKBLK_COUNT, TIMER_COUNT};  // R1 R2 R22
      end else if (hit_perm) begin
         read_word[PERM_ALL_BIT]    = all_source_restrict;
         read_word[PERM_SWITCH_BIT] = switch_only_read_restrict;
      end else if (hit_dint) begin
         read_word[DINT_REQ_BIT]    = debug_interrupt_trigger;
         read_word[DINT_IN_DBG_BIT] = in_debug_mode_flag;  // R7
      end else if (hit_div) begin
         read_word[DIV_WIDTH-1:0]   = clock_divide;
         read_word[DIV_DISABLE_BIT] = clock_disable;
      end else if (hit_sec) begin
         read_word = security_configuration;  // R11
      end else if (hit_scr) begin
         read_word = scratch_word;  // R18
      end else if (hit_pc) begin
         read_word = core0_pc;  // R20
      end
   end

   // one strobe in, one answer a cycle later (R21)
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cfg_ack   <= 1'b0;
         cfg_err   <= 1'b0;
         cfg_rdata <= WORD_ZERO;
      end else begin
         cfg_ack   <= cfg_req;
         cfg_err   <= cfg_req && (!mapped || (cfg_write
                      && (restricted || jtag_pll_refused || sec_refused)));  // R5 R12
         cfg_rdata <= (cfg_req && !cfg_write) ? read_word : WORD_ZERO;  // R22
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   a_cap_counts: assert property (cfg_req && !cfg_write && hit_cap |=>  // R1
      cfg_rdata == {16'h0000, CLKBLK_COUNT, TIMER_COUNT})
      else $error("capability word wrong");
   a_all_restrict: assert property (wr_req && all_source_restrict  // R3
      && cfg_src == SRC_JTAG && hit_scr |-> !write_ok ##1 cfg_err)
      else $error("jtag write passed full restriction");
   a_switch_restrict: assert property (wr_req && switch_only_read_restrict  // R4
      && cfg_src == SRC_SWITCH && hit_div |=> cfg_err && $stable(clock_divide))
      else $error("switch write passed restriction");
   a_refused_keep: assert property (wr_req && restricted && hit_perm |=>  // R5
      $stable(all_source_restrict) && $stable(switch_only_read_restrict))
      else $error("restricted write changed permission");
   a_irq_request: assert property (write_ok && hit_dint && cfg_wdata[DINT_REQ_BIT]  // R6
      && !security_configuration[SEC_GDBG_BIT] && !otp_load |=> ##1 debug_irq_req)
      else $error("debug interrupt not raised");
   a_debug_flag: assert property (cfg_req && !cfg_write && hit_dint |=>  // R7
      cfg_rdata[DINT_IN_DBG_BIT] == $past(in_debug_mode_flag))
      else $error("debug mode flag wrong");
   a_gate_off: assert property (clock_disable |=> !tile_clk_tick)  // R10
      else $error("tile clock runs while disabled");
   a_undivided: assert property (!divider_enable && !clock_disable |=> tile_clk_tick)  // R9
      else $error("divider applied while not enabled");
   a_sec_lock: assert property (wr_req && hit_sec && security_configuration[SEC_WLOCK_BIT]  // R12
      |=> cfg_ack && cfg_err)
      else $error("security write not refused");
   a_jtag_pll: assert property (wr_req && cfg_src == SRC_JTAG && hit_div  // R16
      && security_configuration[SEC_JTAG_PLL_BIT] |=> $stable(clock_divide) && cfg_err)
      else $error("jtag reached divider");
   a_pc_read: assert property (cfg_req && !cfg_write && hit_pc |=> cfg_rdata == $past(core0_pc))  // R20
      else $error("core 0 pc mismatch");
   a_unmapped: assert property (cfg_req && !mapped |=> cfg_err && cfg_rdata == WORD_ZERO)  // R22
      else $error("unmapped access not flagged");
   a_ack_pulse: assert property (cfg_req |=> cfg_ack)  // R21
      else $error("no answer to request");

endmodule

// ### cfg_agent_model.sv
// Purpose : outside agent issuing configuration reads and writes
// Assumes : one strobe cycle per access, answer sampled one cycle on
// Notes   : released data lines show the inverse so stale values never pass
`timescale 1ns/1ps
module cfg_agent_model
   import tile_cfg_pkg::*;
(
   input  wire logic        mclk,
   output logic             cfg_req,
   output logic             cfg_write,
   output logic [1:0]       cfg_src,
   output logic [7:0]       cfg_num,
   output logic [31:0]      cfg_wdata,
   input  wire logic [31:0] cfg_rdata,
   input  wire logic        cfg_ack,
   input  wire logic        cfg_err
);
   initial begin
      cfg_req = 1'b0;
      cfg_write = 1'b0;
      cfg_src = SRC_LOCAL;
      cfg_num = 8'h00;
      cfg_wdata = 32'h0000_0000;
   end

   // registers reached only by numbered config reads and writes
   task automatic access(input logic wr, input logic [1:0] src, input logic [7:0] num,
                         input logic [31:0] wd, output logic [31:0] rd,
                         output logic ack, output logic err);
      @(posedge mclk);
      #1;
      cfg_req = 1'b1;
      cfg_write = wr;
      cfg_src = src;
      cfg_num = num;
      cfg_wdata = wd;
      @(posedge mclk);
      #1;
      cfg_req = 1'b0;
      cfg_num = ~num;
      cfg_wdata = ~wd;
      rd = cfg_rdata;
      ack = cfg_ack;
      err = cfg_err;
   endtask
endmodule

// ### tile_config_debug_regs_test.sv
// Purpose : self-checking bench for the tile config register bank
// Assumes : agent model issues config accesses, one per call
// Notes   : expectations come from literals, the package constants and the saved random words
`timescale 1ns/1ps
module tile_config_debug_regs_test
   import tile_cfg_pkg::*;
;
   logic        mclk, rst_b, cfg_req, cfg_write, cfg_ack, cfg_err, core_scr_req;
   logic        core_scr_write, core_scr_ack, in_debug_mode, divider_enable, otp_load;
   logic        debug_irq_req, tile_clk_tick, tile_clk_gated, global_debug_block;
   logic        jtag_debug_port_block, jtag_pll_block, boot_from_otp_override;
   logic        otp_all_sector_lock, otp_redundancy_enable, ack_v, err_v;
   logic [1:0]  cfg_src;
   logic [2:0]  core_scr_idx;
   logic [3:0]  otp_per_sector_lock;
   logic [7:0]  cfg_num;
   logic [31:0] cfg_wdata, cfg_rdata, core_scr_wdata, core_scr_rdata, core0_pc;
   logic [31:0] otp_security_word, rd_v, pc;
   logic [31:0] sc [8];
   int          seed = 34;
   int          miscompares = 0;
   int          check_count = 0;
   int          ticks = 0;

   tile_config_debug_regs #(.TIMER_COUNT(8'h05), .CLKBLK_COUNT(8'h03)) u_tile_config_debug_regs (
      .mclk, .rst_b, .cfg_req, .cfg_write, .cfg_src, .cfg_num, .cfg_wdata, .cfg_rdata,
      .cfg_ack, .cfg_err, .core_scr_req, .core_scr_write, .core_scr_idx, .core_scr_wdata,
      .core_scr_rdata, .core_scr_ack, .in_debug_mode, .core0_pc, .divider_enable, .otp_load,
      .otp_security_word, .debug_irq_req, .tile_clk_tick, .tile_clk_gated,
      .global_debug_block, .jtag_debug_port_block, .jtag_pll_block, .boot_from_otp_override,
      .otp_all_sector_lock, .otp_per_sector_lock, .otp_redundancy_enable);

   cfg_agent_model u_cfg_agent_model (.mclk, .cfg_req, .cfg_write, .cfg_src, .cfg_num,
      .cfg_wdata, .cfg_rdata, .cfg_ack, .cfg_err);

   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   always @(posedge mclk) if (tile_clk_tick === 1'b1) ticks <= ticks + 1;

   // ----------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic xfer(input logic wr, input logic [1:0] src, input logic [7:0] num,
                       input logic [31:0] wd, input logic [31:0] exp, input logic e);
      u_cfg_agent_model.access(wr, src, num, wd, rd_v, ack_v, err_v);
      chk("cfg_ack", 32'h1, {31'h0, ack_v});
      chk("cfg_err", {31'h0, e}, {31'h0, err_v});
      if (!wr) chk("cfg_rdata", exp, rd_v);
   endtask

   task automatic core(input logic wr, input logic [2:0] idx, input logic [31:0] wd,
                       input logic [31:0] exp);
      @(posedge mclk);
      #1;
      core_scr_req = 1'b1;
      core_scr_write = wr;
      core_scr_idx = idx;
      core_scr_wdata = wd;
      @(posedge mclk);
      #1;
      core_scr_req = 1'b0;
      core_scr_wdata = ~wd;
      chk("core_scr_ack", 32'h1, {31'h0, core_scr_ack});
      if (!wr) chk("core_scr_rdata", exp, core_scr_rdata);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   task automatic results();
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // ----------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------
   initial begin
      rst_b = 1'b0;
      {core_scr_req, core_scr_write, in_debug_mode, divider_enable, otp_load} = 5'h00;
      core_scr_idx = 3'h0;
      core_scr_wdata = 32'h0000_0000;
      core0_pc = 32'h0000_0000;
      otp_security_word = 32'h0000_0000;
      cyc(4);
      rst_b = 1'b1;
      xfer(0, SRC_LOCAL, NUM_CAPABILITY, 0, 32'h0000_0305, 0);
      xfer(0, SRC_LOCAL, NUM_DBG_PERM, 0, 0, 0);
      xfer(0, SRC_LOCAL, NUM_DEBUG_INTERRUPT_REQUEST, 0, 0, 0);
      xfer(0, SRC_LOCAL, NUM_CLK_DIV, 0, 0, 0);
      xfer(0, SRC_LOCAL, NUM_SECURITY, 0, 0, 0);
      xfer(1, SRC_LOCAL, NUM_CAPABILITY, 32'hFFFF_FFFF, 0, 0);
      xfer(0, SRC_LOCAL, NUM_CAPABILITY, 0, 32'h0000_0305, 0);
      xfer(0, SRC_LOCAL, 8'h03, 0, 0, 1);
      pc = $random(seed);
      core0_pc = pc;
      xfer(1, SRC_LOCAL, NUM_CORE0_PC, 32'h0000_1234, 0, 0);
      xfer(0, SRC_SWITCH, NUM_CORE0_PC, 0, pc, 0);
      for (int i = 0; i < SCRATCH_WORDS; i++) begin
         sc[i] = $random(seed);
         xfer(1, SRC_SWITCH, NUM_SCRATCH_BASE + 8'(i), sc[i], 0, 0);
      end
      for (int i = 0; i < SCRATCH_WORDS; i++) begin
         xfer(0, SRC_JTAG, NUM_SCRATCH_BASE + 8'(i), 0, sc[i], 0);
         core(0, 3'(i), 0, sc[i]);
      end
      sc[7] = $random(seed);
      core(1, 3'h7, sc[7], 0);
      xfer(0, SRC_SWITCH, NUM_SCRATCH_LAST, 0, sc[7], 0);
      xfer(1, SRC_SWITCH, NUM_DEBUG_INTERRUPT_REQUEST, 32'hFFFF_FFFD, 0, 0);
      cyc(1);
      chk("debug_irq_req", 32'h1, {31'h0, debug_irq_req});
      xfer(0, SRC_LOCAL, NUM_DEBUG_INTERRUPT_REQUEST, 0, 32'h1, 0);
      in_debug_mode = 1'b1;
      cyc(2);
      xfer(0, SRC_LOCAL, NUM_DEBUG_INTERRUPT_REQUEST, 0, 32'h2, 0);
      in_debug_mode = 1'b0;
      cyc(2);
      xfer(0, SRC_LOCAL, NUM_DEBUG_INTERRUPT_REQUEST, 0, 0, 0);
      // gated clock must give no ticks even with the divider off
      xfer(1, SRC_LOCAL, NUM_CLK_DIV, 32'hFFFF_0003, 0, 0);
      xfer(0, SRC_LOCAL, NUM_CLK_DIV, 0, 32'h8000_0003, 0);
      chk("tile_clk_gated", 32'h1, {31'h0, tile_clk_gated});
      ticks = 0;
      cyc(12);
      chk("ticks gated", 0, 32'(ticks));
      divider_enable = 1'b1;
      xfer(1, SRC_LOCAL, NUM_CLK_DIV, 32'h0000_0003, 0, 0);
      cyc(3);
      ticks = 0;
      cyc(30);
      chk("ticks divided", 32'd10, 32'(ticks));
      divider_enable = 1'b0;
      cyc(3);
      ticks = 0;
      cyc(30);
      chk("ticks undivided", 32'd30, 32'(ticks));
      xfer(1, SRC_LOCAL, NUM_DBG_PERM, 32'h7FFF_FFFF, 0, 0);
      xfer(1, SRC_SWITCH, NUM_DBG_PERM, 32'h0, 0, 1);
      xfer(0, SRC_LOCAL, NUM_DBG_PERM, 0, 32'h1, 0);
      xfer(1, SRC_SWITCH, NUM_SCRATCH_BASE, 32'h0000_00A5, 0, 1);
      xfer(0, SRC_SWITCH, NUM_SCRATCH_BASE, 0, sc[0], 0);
      xfer(1, SRC_SWITCH, NUM_CLK_DIV, 32'h7, 0, 1);
      sc[1] = $random(seed);
      xfer(1, SRC_JTAG, NUM_SCRATCH_BASE + 8'h01, sc[1], 0, 0);
      xfer(1, SRC_LOCAL, NUM_DBG_PERM, 32'h8000_0000, 0, 0);
      xfer(1, SRC_JTAG, NUM_SCRATCH_BASE + 8'h01, 32'h5A, 0, 1);
      xfer(1, SRC_SCRATCH, NUM_DEBUG_INTERRUPT_REQUEST, 32'h1, 0, 1);
      core(1, 3'h1, 32'h5A, 0);
      core(0, 3'h1, 0, sc[1]);
      xfer(0, SRC_JTAG, NUM_SCRATCH_BASE + 8'h01, 0, sc[1], 0);
      xfer(1, SRC_LOCAL, NUM_DBG_PERM, 0, 0, 0);
      otp_security_word = 32'hFFFF_FFFF;
      otp_load = 1'b1;
      cyc(1);
      otp_load = 1'b0;
      cyc(2);
      xfer(0, SRC_JTAG, NUM_SECURITY, 0, SEC_MASK, 0);
      chk("security outputs", 32'h3FF, {22'h0, global_debug_block, jtag_debug_port_block,
          jtag_pll_block, boot_from_otp_override, otp_all_sector_lock,
          otp_per_sector_lock, otp_redundancy_enable});
      xfer(1, SRC_LOCAL, NUM_SECURITY, 32'h0, 0, 1);
      xfer(1, SRC_JTAG, NUM_CLK_DIV, 32'h0000_0005, 0, 1);
      xfer(0, SRC_LOCAL, NUM_CLK_DIV, 0, 32'h3, 0);
      xfer(1, SRC_LOCAL, NUM_DEBUG_INTERRUPT_REQUEST, 32'h1, 0, 0);
      cyc(2);
      chk("debug_irq_req", 0, {31'h0, debug_irq_req});
      results();
   end

   // hang guard, far beyond the few hundred cycles the sequence needs
   initial begin
      #20000;
      miscompares++;
      results();
   end
endmodule
